// ---- bench/board_pins_model.sv ----
// Board side of the pins: pull-ups and an external driver
`timescale 1ns/100ps
`default_nettype none
module board_pins_model
   import gpio_port_pkg::*;
(
   input  wire gpio_port_pkg::port_word_t pin_out_i,
   input  wire gpio_port_pkg::port_word_t pin_oe_i,
   input  wire gpio_port_pkg::port_word_t ext_val_i,
   input  wire gpio_port_pkg::port_word_t ext_en_i,
   output var gpio_port_pkg::port_word_t  pin_in_o
);
   // Released pins float up, so open drain reads high when let go
   assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ~(ext_en_i & ~ext_val_i));
endmodule : board_pins_model
`default_nettype wire

// ---- bench/gpio_port_assertions.sv ----
// Checker on the ports of the shared-pin port
`timescale 1ns/100ps
`default_nettype none
module gpio_port_assertions
   import gpio_port_pkg::*;
(
   input wire logic                      ref_clk_i,
   input wire logic                      rst_b_i,
   input wire gpio_port_pkg::reg_addr_t  reg_addr_i,
   input wire logic                      reg_read_i,
   input wire gpio_port_pkg::port_word_t reg_rdata_o,
   input wire gpio_port_pkg::port_word_t periph_enable_i,
   input wire gpio_port_pkg::port_word_t periph_drive_i,
   input wire gpio_port_pkg::port_word_t periph_data_i,
   input wire gpio_port_pkg::port_word_t periph_in_o,
   input wire gpio_port_pkg::port_word_t pin_out_o,
   input wire gpio_port_pkg::port_word_t pin_oe_o
);
   // Outputs lag the pin reset release by the internal sync stages
   logic [2:0] up;
   port_word_t ed;
   assign ed = periph_enable_i & periph_drive_i & IMPL_MASK;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) up <= 3'h0;
      else up <= {up[1:0], 1'b1};
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence rd_at(reg_addr_t a);
      up[2] && reg_read_i && reg_addr_i == a;
   endsequence
   AST_PERIPH_OWNS:
      assert property (up[2] |=> (pin_oe_o & $past(ed)) == $past(ed)
         && (pin_out_o & $past(ed)) == ($past(periph_data_i) & $past(ed)))
      else $error("peripheral lost its pin");
   AST_RESET_QUIET:
      assert property (disable iff (1'b0) !rst_b_i |-> {pin_oe_o, periph_in_o} == '0)
      else $error("pins driven in reset");
   AST_NO_LOOP:
      assert property (up[2] && $stable(pin_oe_o) && $stable(ed)
         |-> (periph_in_o & pin_oe_o & ~ed) == '0)
      else $error("port output looped to peripheral");
   AST_RDATA_HOLDS:
      assert property (up[2] && !reg_read_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   AST_ABSENT_ZERO:
      assert property (up[2] && $past(reg_read_i) |-> (reg_rdata_o & ~IMPL_MASK) == '0)
      else $error("absent bit read high");
   AST_UNMAPPED_ZERO:
      assert property (rd_at(3'h7) |=> reg_rdata_o == '0)
      else $error("unmapped read not zero");
   AST_DRIVE_STATUS:
      assert property (rd_at(OFS_DRIVE_STATUS) |=> reg_rdata_o == $past(pin_oe_o))
      else $error("drive status wrong");
   AST_OWN_STATUS:
      assert property (rd_at(OFS_PERIPH_OWNERSHIP) |=> reg_rdata_o == $past(ed))
      else $error("ownership status wrong");
endmodule : gpio_port_assertions
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the shared-pin port
`timescale 1ns/100ps
`default_nettype none
module tb;
   import gpio_port_pkg::*;
   logic       ref_clk_i, rst_b_i, wr_s, rd_s;
   reg_addr_t  adr;
   port_word_t wd, rdat, en, dr, dat, pin_in, pin_out, pin_oe, p_in, ext_v, ext_e;
   int         miscompares = 0;
   int         compares = 0;
   shared_pin_parallel_port i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .reg_addr_i(adr), .reg_wdata_i(wd), .reg_write_i(wr_s), .reg_read_i(rd_s),
      .reg_rdata_o(rdat), .periph_enable_i(en), .periph_drive_i(dr), .periph_data_i(dat),
      .periph_in_o(p_in), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
   board_pins_model i_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_val_i(ext_v),
      .ext_en_i(ext_e), .pin_in_o(pin_in));
   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input port_word_t got, input port_word_t exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input reg_addr_t a, input port_word_t d);
      @(posedge ref_clk_i);
      adr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge ref_clk_i);
      wr_s <= 1'b0;
   endtask : wr
   // Leaves an idle cycle after any write before the strobe
   task automatic rd(input reg_addr_t a, input port_word_t exp);
      @(posedge ref_clk_i);
      adr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk_i);
      rd_s <= 1'b0;
      #1 chk(rdat, exp);
   endtask : rd
   // Covers the pin cell flop, the input sync and the peripheral stage
   task automatic pins(input port_word_t oe, input port_word_t o);
      repeat (4) @(posedge ref_clk_i);
      #1 chk(pin_oe, oe);
      chk(pin_out, o);
   endtask : pins
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      miscompares++;
      final_report();
   end
   initial begin
      {wr_s, rd_s, adr, wd, en, dr, dat, ext_v, ext_e} = '0;
      // Reset falls after time zero so every reset flop already waits for the edge
      rst_b_i = 1'b1;
      #1 rst_b_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rd(OFS_PIN_DIRECTION, IMPL_MASK);
      rd(OFS_OUTPUT_LATCH, 16'h0000);
      rd(OFS_OPEN_DRAIN_SELECT, 16'h0000);
      rd(OFS_ANALOG_SELECT, ANALOG_MASK);
      rd(3'h7, 16'h0000);
      $display("test reset values done");
      wr(OFS_ANALOG_SELECT, 16'h0000);
      wr(OFS_PIN_DIRECTION, 16'h0000);
      wr(OFS_OUTPUT_LATCH, 16'hffff);
      rd(OFS_OUTPUT_LATCH, 16'h3fff);
      pins(16'h3fff, 16'h3fff);
      rd(OFS_PIN_LEVEL, 16'h3fff);
      wr(OFS_PIN_LEVEL, 16'h1234);
      rd(OFS_OUTPUT_LATCH, 16'h1234);
      $display("test latch and level done");
      wr(OFS_OUTPUT_LATCH, 16'h000f);
      wr(OFS_OPEN_DRAIN_SELECT, 16'h00ff);
      pins(16'h3ff0, 16'h0000);
      rd(OFS_PIN_LEVEL, 16'h000f);
      $display("test open drain done");
      ext_v <= 16'hffff;
      ext_e <= 16'hffff;
      wr(OFS_OPEN_DRAIN_SELECT, 16'h0000);
      wr(OFS_ANALOG_SELECT, 16'hffff);
      rd(OFS_ANALOG_SELECT, ANALOG_MASK);
      pins(16'h3f00, 16'h000f);
      wr(OFS_PIN_DIRECTION, 16'hffff);
      pins(16'h0000, 16'h000f);
      rd(OFS_PIN_LEVEL, 16'h3f00);
      $display("test analog done");
      ext_e <= 16'h0000;
      wr(OFS_ANALOG_SELECT, 16'h0000);
      wr(OFS_PIN_DIRECTION, 16'h0000);
      wr(OFS_OUTPUT_LATCH, 16'h00c0);
      en <= 16'h00f0;
      dr <= 16'h0030;
      dat <= 16'h0010;
      pins(16'h3fff, 16'h00d0);
      chk(p_in & IMPL_MASK, 16'h0010);
      rd(OFS_PERIPH_OWNERSHIP, 16'h0030);
      rd(OFS_DRIVE_STATUS, 16'h3fff);
      rd(OFS_PIN_LEVEL, 16'h00d0);
      $display("test peripheral sharing done");
      // Reset moves on a rising edge like every other design input
      @(posedge ref_clk_i);
      rst_b_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 chk(pin_oe, 16'h0000);
      chk(p_in, 16'h0000);
      @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rd(OFS_PIN_DIRECTION, IMPL_MASK);
      $display("test second reset done");
      final_report();
   end
endmodule : tb
bind shared_pin_parallel_port gpio_port_assertions i_chk (.ref_clk_i, .rst_b_i, .reg_addr_i,
   .reg_read_i, .reg_rdata_o, .periph_enable_i, .periph_drive_i, .periph_data_i,
   .periph_in_o, .pin_out_o, .pin_oe_o);
`default_nettype wire

// ---- hw/gpio_pin_cell.sv ----
// One pin of the shared port: output muxes, open drain, loop-through block
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_cell (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_sync_b_i,
   // Per-pin configuration
   input  wire logic present_i,
   input  wire logic direction_i,
   input  wire logic latch_i,
   input  wire logic open_drain_i,
   input  wire logic analog_i,
   // Sharing peripheral
   input  wire logic periph_enable_i,
   input  wire logic periph_drive_i,
   input  wire logic periph_data_i,
   output logic      periph_in_o,
   // Pin, already synchronised
   input  wire logic pin_sync_i,
   output logic      pin_out_o,
   output logic      pin_oe_o,
   output logic      level_o,
   output logic      owned_o
);
   logic periph_owns;
   logic port_oe;
   logic next_out;
   logic next_oe;

   // Peripheral wins only while enabled and actively driving
   assign periph_owns = present_i & periph_enable_i & periph_drive_i;

   // Port drives only as a digital output; open drain releases on a one
   assign port_oe = present_i & ~direction_i & ~analog_i
                    & ~(open_drain_i & latch_i);

   always_comb begin
      next_out = 1'b0;
      next_oe  = 1'b0;
      if (periph_owns) begin
         next_out = periph_data_i;
         next_oe  = 1'b1;
      end else begin
         next_out = open_drain_i ? 1'b0 : latch_i;
         next_oe  = port_oe;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_b_i) begin
      if (!rst_sync_b_i) begin
         pin_out_o <= 1'b0;
         pin_oe_o  <= 1'b0;
      end else begin
         pin_out_o <= next_out;
         pin_oe_o  <= next_oe;
      end
   end

   // Peripheral does not see what the port itself drives, except for three cycles after the port gives up the pin
   always_ff @(posedge ref_clk_i or negedge rst_sync_b_i) begin
      if (!rst_sync_b_i) begin
         periph_in_o <= 1'b0;
      end else begin
         periph_in_o <= (port_oe & ~periph_owns) ? 1'b0 : pin_sync_i & present_i;
      end
   end

   // Analog inputs read low; absent bits read zero
   assign level_o = present_i & ~analog_i & pin_sync_i;
   assign owned_o = periph_owns;
endmodule : gpio_pin_cell
`default_nettype wire

// ---- hw/gpio_port_pkg.sv ----
// Constants shared by the shared-pin parallel port and its bench
package gpio_port_pkg;
   localparam int unsigned PORT_W = 16;
   localparam int unsigned ADDR_W = 3;

   typedef logic [PORT_W-1:0] port_word_t;
   typedef logic [ADDR_W-1:0] reg_addr_t;

   // Register offsets (word index on the plain register port)
   localparam reg_addr_t OFS_PIN_DIRECTION     = 3'h0;
   localparam reg_addr_t OFS_OUTPUT_LATCH      = 3'h1;
   localparam reg_addr_t OFS_PIN_LEVEL         = 3'h2;
   localparam reg_addr_t OFS_OPEN_DRAIN_SELECT = 3'h3;
   localparam reg_addr_t OFS_ANALOG_SELECT     = 3'h4;
   localparam reg_addr_t OFS_PERIPH_OWNERSHIP  = 3'h5;
   localparam reg_addr_t OFS_DRIVE_STATUS      = 3'h6;

   // Bits present on this build; absent bits are held at zero
   localparam port_word_t IMPL_MASK   = 16'h3fff;
   // Bits that carry an analog function
   localparam port_word_t ANALOG_MASK = 16'h00ff;

   // Reset values
   localparam port_word_t DIRECTION_RESET  = IMPL_MASK;
   localparam port_word_t LATCH_RESET      = 16'h0000;
   localparam port_word_t OPEN_DRAIN_RESET = 16'h0000;
   localparam port_word_t ANALOG_RESET     = ANALOG_MASK;
   localparam port_word_t ZERO_WORD        = 16'h0000;
endpackage : gpio_port_pkg

// ---- hw/shared_pin_parallel_port.sv ----
// Shared-pin general parallel io port: registers, pin sync, per-pin cells
// Function
// - Per pin, muxes pick peripheral or port for output data and enable.
// - Actively driving enabled peripheral disables port driver; pin still readable.
// - Enabled but idle peripheral leaves pin drivable from the port latch.
// - Port output does not loop back into the sharing peripheral's input, except for three cycles after the port gives up the pin.
// - Direction bit one makes pin input, zero makes it output.
// - Every reset leaves all pins as inputs.
// - Latch register reads stored latch; writes update latch.
// - Pin level register reads pins; writes update the output latch.
// - Absent bits disabled; latch, direction and level read zero.
// - Per-pin open-drain select turns push-pull output into open drain.
// - Analog-select bit with direction bit picks analog or digital function; here analog select alone disables driver and digital read.
// - Analog-configured pins read low through the pin level register.
`timescale 1ns/100ps
`default_nettype none
module shared_pin_parallel_port
   import gpio_port_pkg::*;
(
   // Clock and reset
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_b_i,
   // Register port
   input  wire gpio_port_pkg::reg_addr_t  reg_addr_i,
   input  wire gpio_port_pkg::port_word_t reg_wdata_i,
   input  wire logic                      reg_write_i,
   input  wire logic                      reg_read_i,
   output gpio_port_pkg::port_word_t      reg_rdata_o,
   // Sharing peripherals
   input  wire gpio_port_pkg::port_word_t periph_enable_i,
   input  wire gpio_port_pkg::port_word_t periph_drive_i,
   input  wire gpio_port_pkg::port_word_t periph_data_i,
   output gpio_port_pkg::port_word_t      periph_in_o,
   // Pins
   input  wire gpio_port_pkg::port_word_t pin_in_i,
   output gpio_port_pkg::port_word_t      pin_out_o,
   output gpio_port_pkg::port_word_t      pin_oe_o
);
   import gpio_port_pkg::*;

   logic       rst_meta_b;
   logic       rst_sync_b;
   port_word_t pin_meta;
   port_word_t pin_sync;
   port_word_t pin_direction;
   port_word_t output_latch;
   port_word_t open_drain_select;
   port_word_t analog_select;
   port_word_t level_word;
   port_word_t owned_word;
   port_word_t next_rdata;

   function automatic logic hit(input reg_addr_t addr, input reg_addr_t ofs);
      hit = (addr == ofs);
   endfunction : hit

   // Reset release through two flops
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // Pins are asynchronous to the clock; first stage read only by second
   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pin_meta <= ZERO_WORD;
         pin_sync <= ZERO_WORD;
      end else begin
         pin_meta <= pin_in_i;
         pin_sync <= pin_meta;
      end
   end

   // Direction: all inputs after any reset
   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pin_direction <= DIRECTION_RESET;
      end else if (reg_write_i && hit(reg_addr_i, OFS_PIN_DIRECTION)) begin
         pin_direction <= reg_wdata_i & IMPL_MASK;
      end
   end

   // Latch is written through its own offset and through the level offset
   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         output_latch <= LATCH_RESET;
      end else if (reg_write_i && (hit(reg_addr_i, OFS_OUTPUT_LATCH) ||
                                   hit(reg_addr_i, OFS_PIN_LEVEL))) begin
         output_latch <= reg_wdata_i & IMPL_MASK;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         open_drain_select <= OPEN_DRAIN_RESET;
      end else if (reg_write_i && hit(reg_addr_i, OFS_OPEN_DRAIN_SELECT)) begin
         open_drain_select <= reg_wdata_i & IMPL_MASK;
      end
   end

   // Only analog-capable bits hold an analog select
   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         analog_select <= ANALOG_RESET & IMPL_MASK;
      end else if (reg_write_i && hit(reg_addr_i, OFS_ANALOG_SELECT)) begin
         analog_select <= reg_wdata_i & ANALOG_MASK & IMPL_MASK;
      end
   end

   // One cell per pin, bit n to pin n
   for (genvar n = 0; n < PORT_W; n++) begin : g_pin
      gpio_pin_cell u_cell (
         .ref_clk_i       (ref_clk_i),
         .rst_sync_b_i    (rst_sync_b),
         .present_i       (IMPL_MASK[n]),
         .direction_i     (pin_direction[n]),
         .latch_i         (output_latch[n]),
         .open_drain_i    (open_drain_select[n]),
         .analog_i        (analog_select[n]),
         .periph_enable_i (periph_enable_i[n]),
         .periph_drive_i  (periph_drive_i[n]),
         .periph_data_i   (periph_data_i[n]),
         .periph_in_o     (periph_in_o[n]),
         .pin_sync_i      (pin_sync[n]),
         .pin_out_o       (pin_out_o[n]),
         .pin_oe_o        (pin_oe_o[n]),
         .level_o         (level_word[n]),
         .owned_o         (owned_word[n])
      );
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = ZERO_WORD;
      unique case (reg_addr_i)
         OFS_PIN_DIRECTION:     next_rdata = pin_direction;
         OFS_OUTPUT_LATCH:      next_rdata = output_latch;
         OFS_PIN_LEVEL:         next_rdata = level_word;
         OFS_OPEN_DRAIN_SELECT: next_rdata = open_drain_select;
         OFS_ANALOG_SELECT:     next_rdata = analog_select;
         OFS_PERIPH_OWNERSHIP:  next_rdata = owned_word;
         OFS_DRIVE_STATUS:      next_rdata = pin_oe_o;
         default:               next_rdata = ZERO_WORD;
      endcase
   end

   // Data stands from the cycle after the read until the next read
   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         reg_rdata_o <= ZERO_WORD;
      end else if (reg_read_i) begin
         reg_rdata_o <= next_rdata;
      end
   end
endmodule : shared_pin_parallel_port
`default_nettype wire
